// [sbc_link_assertions.sv]
// sbc_link_assertions: command pin checks between the two ends
////////////////////////////////////////////////////////////////////////////
module sbc_link_assertions #(
  parameter int BURST_LEN = sbc_pkg::BURST_LEN
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // command pins
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [sbc_pkg::BANK_W-1:0] bankSel,
  input wire logic [sbc_pkg::ADDR_W-1:0] addr
);
  localparam int AP_CYC = BURST_LEN + sbc_pkg::PRECHARGE_PERIOD_CYC;
  wire [2:0] cmd;
  wire bitTen;
  wire isAct;
  wire isPre;
  wire isCol;
  wire isDev;
  wire bankCmd;
  wire anyAp;
  logic [3:0] rowOpen;
  logic [5:0] apLeft [4];
  assign cmd = {rasN, casN, weN};
  assign bitTen = addr[sbc_pkg::ADDR_AP_BIT];
  assign isAct = !csN && cmd == sbc_pkg::CMD_ACTIVE;
  assign isPre = !csN && cmd == sbc_pkg::CMD_PRE;
  assign isCol = !csN && (cmd == sbc_pkg::CMD_READ ||
                          cmd == sbc_pkg::CMD_WRITE);
  assign isDev = !csN && (cmd == sbc_pkg::CMD_REFRESH ||
                          cmd == sbc_pkg::CMD_MODE);
  assign bankCmd = isAct || isPre || isCol;
  assign anyAp = (apLeft[0] != 6'h0) || (apLeft[1] != 6'h0) ||
                 (apLeft[2] != 6'h0) || (apLeft[3] != 6'h0);
  ////////////////////////////////////////////////////////////////////////////
  // shadow of open rows and auto precharge waits, seen from the pins only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rowOpen <= 4'h0;
      for (int b = 0; b < 4; b++) apLeft[b] <= 6'h0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (isCol && bitTen && bankSel == 2'(b)) apLeft[b] <= 6'(AP_CYC - 1);
        else if (apLeft[b] != 6'h0) apLeft[b] <= apLeft[b] - 6'h1;
        if (isAct && bankSel == 2'(b)) rowOpen[b] <= 1'b1;
        else if ((isPre || isCol) && bitTen) rowOpen[b] <=
          (isCol && bankSel != 2'(b)) ? rowOpen[b] : 1'b0;
        else if (isPre && bankSel == 2'(b)) rowOpen[b] <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_clock_enable_high: assert property (cke)
    else $error("clock enable dropped");
  a_first_cycle_idle: assert property ($rose(reset_n) |-> csN)
    else $error("command right at reset release");
  a_mode_then_quiet: assert property (
    !csN && cmd == sbc_pkg::CMD_MODE |=> (csN || cmd == sbc_pkg::CMD_NOP))
    else $error("command during mode load wait");
  a_ap_bank_quiet: assert property (
    bankCmd |-> apLeft[bankSel] == 6'h0)
    else $error("command to bank in auto precharge");
  a_devwide_all_idle: assert property (
    isDev |-> rowOpen == 4'h0 && !anyAp)
    else $error("refresh or mode load with bank busy");
  a_prechg_all_free: assert property (isPre && bitTen |-> !anyAp)
    else $error("precharge all with bank busy");
  a_column_row_open: assert property (isCol |-> rowOpen[bankSel])
    else $error("column command to closed row");
  a_activate_row_shut: assert property (isAct |-> !rowOpen[bankSel])
    else $error("activate to open row");
endmodule : sbc_link_assertions

// [sbc_link_if.sv]
// sbc_link_if: command pins between memory controller and device
interface sbc_link_if;
  logic cke;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic [sbc_pkg::BANK_W-1:0] bankSel;
  logic [sbc_pkg::ADDR_W-1:0] addr;
  modport ctrl (output cke, csN, rasN, casN, weN, bankSel, addr);
  modport dev (input cke, csN, rasN, casN, weN, bankSel, addr);
endinterface : sbc_link_if

// [sbc_pkg.sv]
// sbc_pkg: constants, types and helpers for the bank command link
package sbc_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 1 << BANK_W;
  localparam int ADDR_W = 13;
  localparam int ADDR_AP_BIT = 10;
  localparam int TIMER_W = 6;
  localparam int BURST_LEN = 4;
  localparam int PRECHARGE_PERIOD_NS = 20;
  localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 20;
  localparam int REFRESH_CYCLE_TIME_NS = 66;
  localparam int SELF_REFRESH_EXIT_DELAY_NS = 75;
  localparam int MODE_LOAD_DELAY_CYC = 2;
  localparam logic CKE_RESET = 1'b1;

  // least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int PRECHARGE_PERIOD_CYC = ns_to_cyc(PRECHARGE_PERIOD_NS);
  localparam int ACTIVATE_TO_COLUMN_DELAY_CYC =
    ns_to_cyc(ACTIVATE_TO_COLUMN_DELAY_NS);
  localparam int REFRESH_CYCLE_TIME_CYC = ns_to_cyc(REFRESH_CYCLE_TIME_NS);
  localparam int SELF_REFRESH_EXIT_DELAY_CYC =
    ns_to_cyc(SELF_REFRESH_EXIT_DELAY_NS);

  // command codes equal the {row, column, write} strobe levels
  typedef enum logic [2:0] {
    CMD_MODE = 3'h0,
    CMD_REFRESH = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACTIVE = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_READ = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } sbc_cmd_t;

  typedef enum logic [2:0] {
    BS_IDLE = 3'h0,
    BS_ACTIVATING = 3'h1,
    BS_ACTIVE = 3'h3,
    BS_READ = 3'h2,
    BS_WRITE = 3'h6,
    BS_READ_AP = 3'h7,
    BS_WRITE_AP = 3'h5,
    BS_PRECHARGING = 3'h4
  } sbc_bank_state_t;

  typedef enum logic [1:0] {
    DS_NORMAL = 2'h0,
    DS_REFRESH = 2'h1,
    DS_MODE = 2'h3
  } sbc_dev_state_t;

  function automatic logic col_ok(input sbc_bank_state_t s);
    return s == BS_ACTIVE || s == BS_READ || s == BS_WRITE;
  endfunction : col_ok

  function automatic logic pre_ok(input sbc_bank_state_t s);
    return s == BS_IDLE || col_ok(s);
  endfunction : pre_ok

  // state a bank stands in once its timer has run out
  function automatic sbc_bank_state_t settle(input sbc_bank_state_t s,
                                             input logic done);
    sbc_bank_state_t r;
    r = s;
    if (done) begin
      unique case (s)
        BS_ACTIVATING, BS_READ, BS_WRITE: r = BS_ACTIVE;
        BS_READ_AP, BS_WRITE_AP, BS_PRECHARGING: r = BS_IDLE;
        BS_IDLE, BS_ACTIVE: r = s;
      endcase
    end
    return r;
  endfunction : settle
endpackage : sbc_pkg

// [sbc_sdram_bank_command_state_bench.sv]
// sbc_sdram_bank_command_state_bench: both ends joined, user sides checked
////////////////////////////////////////////////////////////////////////////
module sbc_sdram_bank_command_state_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BL = 4;
  localparam int RP = sbc_pkg::PRECHARGE_PERIOD_CYC;
  localparam int RCD = sbc_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC;
  localparam int RFC = sbc_pkg::REFRESH_CYCLE_TIME_CYC;
  localparam int MD = sbc_pkg::MODE_LOAD_DELAY_CYC;
  logic clk;
  logic reset_n;
  logic reqValid;
  sbc_pkg::sbc_cmd_t reqCmd;
  logic [sbc_pkg::BANK_W-1:0] reqBank;
  logic [sbc_pkg::ADDR_W-1:0] reqAddr;
  logic reqReady;
  sbc_pkg::sbc_bank_state_t bankState [sbc_pkg::NUM_BANKS];
  sbc_pkg::sbc_dev_state_t devState;
  logic cmdIllegal;
  logic [sbc_pkg::ADDR_W-1:0] modeWord;
  logic [sbc_pkg::BANK_W-1:0] lastBurstBank;
  int failCount = 0;
  int nChecks = 0;
  int cycles = 0;
  int illegalSeen = 0;
  sbc_pkg::sbc_cmd_t colCmd [2] = '{sbc_pkg::CMD_READ, sbc_pkg::CMD_WRITE};
  sbc_pkg::sbc_bank_state_t apState [2] =
    '{sbc_pkg::BS_READ_AP, sbc_pkg::BS_WRITE_AP};
  sbc_link_if linkBus();
  sbc_sdram_ctrl #(.BURST_LEN(BL)) i_sbc_sdram_ctrl (.clk(clk),
    .reset_n(reset_n), .reqValid(reqValid), .reqCmd(reqCmd),
    .reqBank(reqBank), .reqAddr(reqAddr), .reqReady(reqReady),
    .link(linkBus));
  sbc_sdram_dev #(.BURST_LEN(BL)) i_sbc_sdram_dev (.clk(clk),
    .reset_n(reset_n), .link(linkBus), .bankState(bankState),
    .devState(devState), .cmdIllegal(cmdIllegal), .modeWord(modeWord),
    .lastBurstBank(lastBurstBank));
  sbc_link_assertions #(.BURST_LEN(BL)) i_sbc_link_assertions (.clk(clk),
    .reset_n(reset_n), .cke(linkBus.cke), .csN(linkBus.csN),
    .rasN(linkBus.rasN), .casN(linkBus.casN), .weN(linkBus.weN),
    .bankSel(linkBus.bankSel), .addr(linkBus.addr));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic completeRun();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : completeRun
  // hang guard, well above the roughly 80 cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failCount++;
      completeRun();
    end
  end
  // every unsupported command the device flags is counted
  always @(posedge clk) begin
    if (cmdIllegal !== 1'b0) illegalSeen++;
  end
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // holds the request until taken, at most 50 edges; returns at the taking edge
  task automatic issue(sbc_pkg::sbc_cmd_t c, logic [1:0] b, logic [12:0] a);
    int n;
    n = 0;
    reqValid <= 1'b1;
    reqCmd <= c;
    reqBank <= b;
    reqAddr <= a;
    do begin
      @(posedge clk);
      n++;
    end while (reqReady !== 1'b1 && n < 50);
    if (reqReady !== 1'b1) check("reqReady", 16'(reqReady), 16'h1);
  endtask : issue
  task automatic idle(int n);
    reqValid <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic seeBank(int b, sbc_pkg::sbc_bank_state_t exp);
    check($sformatf("bank%0d", b), 16'(bankState[b]), 16'(exp));
  endtask : seeBank
  task automatic seeDev(sbc_pkg::sbc_dev_state_t exp);
    check("devState", 16'(devState), 16'(exp));
  endtask : seeDev
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    reqValid = 1'b0;
    reqCmd = sbc_pkg::CMD_NOP;
    reqBank = 2'h0;
    reqAddr = 13'h0000;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    idle(2);
    for (int b = 0; b < 4; b++) seeBank(b, sbc_pkg::BS_IDLE);
    seeDev(sbc_pkg::DS_NORMAL);
    check("modeWord", 16'(modeWord), 16'h0000);
    $display("test reset done");
    issue(sbc_pkg::CMD_MODE, 2'h0, 13'h0123);
    idle(2);
    seeDev(sbc_pkg::DS_MODE);
    check("modeWord", 16'(modeWord), 16'h0123);
    idle(MD);
    seeDev(sbc_pkg::DS_NORMAL);
    issue(sbc_pkg::CMD_REFRESH, 2'h0, 13'h0000);
    idle(2);
    seeDev(sbc_pkg::DS_REFRESH);
    idle(RFC);
    seeDev(sbc_pkg::DS_NORMAL);
    $display("test device wide done");
    issue(sbc_pkg::CMD_ACTIVE, 2'h0, 13'h0000);
    idle(2);
    seeBank(0, sbc_pkg::BS_ACTIVATING);
    idle(RCD);
    seeBank(0, sbc_pkg::BS_ACTIVE);
    // back to back read, write, stop: each lands one edge later
    issue(sbc_pkg::CMD_READ, 2'h0, 13'h0008);
    issue(sbc_pkg::CMD_WRITE, 2'h0, 13'h000c);
    issue(sbc_pkg::CMD_BST, 2'h0, 13'h0000);
    seeBank(0, sbc_pkg::BS_READ);
    check("lastBurstBank", 16'(lastBurstBank), 16'h0);
    idle(1);
    seeBank(0, sbc_pkg::BS_WRITE);
    idle(1);
    seeBank(0, sbc_pkg::BS_ACTIVE);
    issue(sbc_pkg::CMD_READ, 2'h0, 13'h0000);
    issue(sbc_pkg::CMD_NOP, 2'h0, 13'h0000);
    idle(2);
    seeBank(0, sbc_pkg::BS_READ);
    idle(BL);
    seeBank(0, sbc_pkg::BS_ACTIVE);
    $display("test bursts done");
    for (int i = 0; i < 2; i++) begin
      issue(sbc_pkg::CMD_ACTIVE, 2'h1, 13'h0000);
      issue(colCmd[i], 2'h1, 13'h0010);
      issue(sbc_pkg::CMD_PRE, 2'h1, 13'h0000);
      idle(2);
      seeBank(1, sbc_pkg::BS_PRECHARGING);
      idle(RP);
      seeBank(1, sbc_pkg::BS_IDLE);
    end
    for (int i = 0; i < 2; i++) begin
      issue(sbc_pkg::CMD_ACTIVE, 2'h2, 13'h0000);
      issue(colCmd[i], 2'h2, 13'h0400);
      idle(2);
      seeBank(2, apState[i]);
      check("lastBurstBank", 16'(lastBurstBank), 16'h2);
      idle(BL + RP - 1);
      seeBank(2, apState[i]);
      idle(1);
      seeBank(2, sbc_pkg::BS_IDLE);
    end
    $display("test precharge done");
    issue(sbc_pkg::CMD_PRE, 2'h3, 13'h0000);
    idle(2);
    seeBank(3, sbc_pkg::BS_IDLE);
    check("cmdIllegal", 16'(cmdIllegal), 16'h0);
    idle(1);
    check("cmdIllegal", 16'(cmdIllegal), 16'h0);
    // bank 0 still open, bank 1 freshly opened, bank select ignored
    issue(sbc_pkg::CMD_ACTIVE, 2'h1, 13'h0000);
    issue(sbc_pkg::CMD_PRE, 2'h2, 13'h0400);
    idle(2);
    for (int b = 0; b < 4; b++) seeBank(b, sbc_pkg::BS_PRECHARGING);
    idle(RP);
    for (int b = 0; b < 4; b++) seeBank(b, sbc_pkg::BS_IDLE);
    $display("test precharge all done");
    // no burst left to stop, so a stop must be refused
    reqCmd <= sbc_pkg::CMD_BST;
    idle(1);
    check("reqReady", 16'(reqReady), 16'h0);
    idle(2);
    check("illegalSeen", 16'(illegalSeen), 16'h0);
    $display("test legality done");
    completeRun();
  end
endmodule : sbc_sdram_bank_command_state_bench

// [sbc_sdram_ctrl.sv]
// sbc_sdram_ctrl: controller end that only issues supported commands
module sbc_sdram_ctrl #(
  parameter int BURST_LEN = sbc_pkg::BURST_LEN
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // request port
  input wire logic reqValid,
  input sbc_pkg::sbc_cmd_t reqCmd,
  input wire logic [sbc_pkg::BANK_W-1:0] reqBank,
  input wire logic [sbc_pkg::ADDR_W-1:0] reqAddr,
  output logic reqReady,
  // command pins
  sbc_link_if.ctrl link
);
  localparam int NB = sbc_pkg::NUM_BANKS;
  localparam int BW = sbc_pkg::BANK_W;
  localparam int TW = sbc_pkg::TIMER_W;
  localparam logic [TW-1:0] WAIT_RCD =
    TW'(sbc_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC);
  localparam logic [TW-1:0] WAIT_RP = TW'(sbc_pkg::PRECHARGE_PERIOD_CYC);
  localparam logic [TW-1:0] WAIT_AP =
    TW'(BURST_LEN + sbc_pkg::PRECHARGE_PERIOD_CYC);
  localparam logic [TW-1:0] WAIT_RFC =
    TW'(sbc_pkg::REFRESH_CYCLE_TIME_CYC);
  localparam logic [TW-1:0] WAIT_MRD = TW'(sbc_pkg::MODE_LOAD_DELAY_CYC);
  localparam logic [TW-1:0] STOP_LEFT = TW'(BURST_LEN - 1);

  ////////////////////////////////////////////////////////////////////////////
  // legality check

  wire [NB-1:0] bankFree;
  wire [NB-1:0] openVec;
  logic [TW-1:0] devWait;
  logic legal;
  logic [TW-1:0] burstLeft;
  logic [BW-1:0] burstBank;
  wire devFree = devWait == '0;
  wire allFree = devFree && (&bankFree);
  wire apBit = reqAddr[sbc_pkg::ADDR_AP_BIT];
  wire selFree = devFree && bankFree[reqBank];
  wire selOpen = openVec[reqBank];

  // conservative: a bank waits out every timer but the burst before the next command
  always_comb begin
    unique case (reqCmd)
      sbc_pkg::CMD_NOP: legal = 1'b1;
      sbc_pkg::CMD_ACTIVE: legal = selFree && !selOpen;
      sbc_pkg::CMD_READ, sbc_pkg::CMD_WRITE:
        legal = selFree && selOpen;
      sbc_pkg::CMD_PRE: legal = apBit ? allFree : selFree;
      sbc_pkg::CMD_BST: legal = devFree && burstLeft != '0;
      sbc_pkg::CMD_REFRESH, sbc_pkg::CMD_MODE:
        legal = allFree && openVec == '0;
    endcase
  end

  assign reqReady = legal;
  wire fire = reqValid && legal;
  wire colFire = fire && (reqCmd == sbc_pkg::CMD_READ ||
                          reqCmd == sbc_pkg::CMD_WRITE);
  wire burstEnd = fire && (reqCmd == sbc_pkg::CMD_BST ||
    (reqCmd == sbc_pkg::CMD_PRE && (apBit || reqBank == burstBank)));

  ////////////////////////////////////////////////////////////////////////////
  // bank mirrors

  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic rowOpen;
    logic [TW-1:0] waitCnt;
    wire hit = fire && reqBank == BW'(b);
    wire preHit = fire && reqCmd == sbc_pkg::CMD_PRE &&
                  (apBit || (reqBank == BW'(b) && rowOpen));
    wire colHit = hit && (reqCmd == sbc_pkg::CMD_READ ||
                          reqCmd == sbc_pkg::CMD_WRITE);
    assign bankFree[b] = waitCnt == '0;
    assign openVec[b] = rowOpen;

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        rowOpen <= 1'b0;
        waitCnt <= '0;
      end else if (preHit) begin
        rowOpen <= 1'b0;
        waitCnt <= WAIT_RP;
      end else if (hit && reqCmd == sbc_pkg::CMD_ACTIVE) begin
        rowOpen <= 1'b1;
        waitCnt <= WAIT_RCD;
      end else if (colHit && apBit) begin
        rowOpen <= 1'b0;
        waitCnt <= WAIT_AP;
      end else if (waitCnt != '0) begin
        waitCnt <= waitCnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      devWait <= '0;
    end else if (fire && reqCmd == sbc_pkg::CMD_REFRESH) begin
      devWait <= WAIT_RFC;
    end else if (fire && reqCmd == sbc_pkg::CMD_MODE) begin
      devWait <= WAIT_MRD;
    end else if (devWait != '0) begin
      devWait <= devWait - 1'b1;
    end
  end

  // a stop needs the newest burst still running without auto precharge;
  // pins lag one edge, so the device sees it one cycle later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      burstLeft <= '0;
      burstBank <= '0;
    end else if (colFire) begin
      burstLeft <= apBit ? '0 : STOP_LEFT;
      burstBank <= reqBank;
    end else if (burstEnd) begin
      burstLeft <= '0;
    end else if (burstLeft != '0) begin
      burstLeft <= burstLeft - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  // idle cycles show inhibit so the device never sees a stray command
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link.cke <= sbc_pkg::CKE_RESET;
      link.csN <= 1'b1;
      {link.rasN, link.casN, link.weN} <= sbc_pkg::CMD_NOP;
      link.bankSel <= '0;
      link.addr <= '0;
    end else begin
      link.cke <= sbc_pkg::CKE_RESET;
      link.csN <= !fire;
      {link.rasN, link.casN, link.weN} <= fire ? reqCmd : sbc_pkg::CMD_NOP;
      link.bankSel <= reqBank;
      link.addr <= reqAddr;
    end
  end
endmodule : sbc_sdram_ctrl

// [sbc_sdram_dev.sv]
// sbc_sdram_dev: per-bank command decode and state of the memory device
module sbc_sdram_dev #(
  parameter int BURST_LEN = sbc_pkg::BURST_LEN
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // command pins
  sbc_link_if.dev link,
  // state for the user side
  output sbc_pkg::sbc_bank_state_t bankState [sbc_pkg::NUM_BANKS],
  output sbc_pkg::sbc_dev_state_t devState,
  output logic cmdIllegal,
  output logic [sbc_pkg::ADDR_W-1:0] modeWord,
  output logic [sbc_pkg::BANK_W-1:0] lastBurstBank
);
  localparam int NB = sbc_pkg::NUM_BANKS;
  localparam int BW = sbc_pkg::BANK_W;
  localparam int TW = sbc_pkg::TIMER_W;
  localparam logic [TW-1:0] LOAD_RCD =
    TW'(sbc_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC - 1);
  localparam logic [TW-1:0] LOAD_RP =
    TW'(sbc_pkg::PRECHARGE_PERIOD_CYC - 1);
  localparam logic [TW-1:0] LOAD_BURST = TW'(BURST_LEN - 1);
  localparam logic [TW-1:0] LOAD_AP =
    TW'(BURST_LEN + sbc_pkg::PRECHARGE_PERIOD_CYC - 1);
  localparam logic [TW-1:0] LOAD_RFC =
    TW'(sbc_pkg::REFRESH_CYCLE_TIME_CYC - 1);
  localparam logic [TW-1:0] LOAD_MRD =
    TW'(sbc_pkg::MODE_LOAD_DELAY_CYC - 1);
  localparam logic [TW-1:0] LOAD_XSR =
    TW'(sbc_pkg::SELF_REFRESH_EXIT_DELAY_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  logic ckePrev;
  logic selfRefresh;
  logic [TW-1:0] exitTimer;
  logic [TW-1:0] devTimer;
  sbc_pkg::sbc_dev_state_t curDev;
  sbc_pkg::sbc_dev_state_t next_devState;
  logic [TW-1:0] next_devTimer;
  sbc_pkg::sbc_bank_state_t curState [NB];
  wire [NB-1:0] idleVec;
  wire [NB-1:0] preOkVec;
  logic next_illegal;

  wire decodeEn = ckePrev && link.cke && !selfRefresh &&
                  exitTimer == '0;
  wire cmdTaken = decodeEn && !link.csN;
  wire sbc_pkg::sbc_cmd_t raw =
    sbc_pkg::sbc_cmd_t'({link.rasN, link.casN, link.weN});
  wire devNormal = curDev == sbc_pkg::DS_NORMAL;
  // nothing executes while the whole device is busy
  wire sbc_pkg::sbc_cmd_t cmd =
    (cmdTaken && devNormal) ? raw : sbc_pkg::CMD_NOP;
  wire apBit = link.addr[sbc_pkg::ADDR_AP_BIT];
  wire allIdle = &idleVec;
  wire sbc_pkg::sbc_bank_state_t selCur = curState[link.bankSel];
  wire sbc_pkg::sbc_bank_state_t lastCur = curState[lastBurstBank];
  wire colCmd = cmd == sbc_pkg::CMD_READ || cmd == sbc_pkg::CMD_WRITE;
  wire colTaken = colCmd && sbc_pkg::col_ok(selCur);
  wire srEnter = ckePrev && !link.cke && !link.csN && devNormal &&
                 raw == sbc_pkg::CMD_REFRESH && allIdle;

  ////////////////////////////////////////////////////////////////////////////
  // per-bank state

  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic [TW-1:0] timer;
    sbc_pkg::sbc_bank_state_t next_state;
    logic [TW-1:0] next_timer;
    wire sel = link.bankSel == BW'(b);
    wire tDone = timer == '0;
    wire sbc_pkg::sbc_bank_state_t cur =
      sbc_pkg::settle(bankState[b], tDone);
    wire preHit = cmd == sbc_pkg::CMD_PRE && (apBit || sel);
    wire colHit = colCmd && sel;
    wire stopHit = cmd == sbc_pkg::CMD_BST && lastBurstBank == BW'(b);

    assign curState[b] = cur;
    assign idleVec[b] = cur == sbc_pkg::BS_IDLE;
    assign preOkVec[b] = sbc_pkg::pre_ok(cur);

    // one counter per bank covers activate, burst and precharge
    always_comb begin
      next_state = cur;
      next_timer = tDone ? '0 : timer - 1'b1;
      unique case (cur)
        sbc_pkg::BS_IDLE: begin
          if (preHit && apBit && (&preOkVec)) begin
            next_state = sbc_pkg::BS_PRECHARGING;
            next_timer = LOAD_RP;
          end else if (cmd == sbc_pkg::CMD_ACTIVE && sel) begin
            next_state = sbc_pkg::BS_ACTIVATING;
            next_timer = LOAD_RCD;
          end
        end
        sbc_pkg::BS_ACTIVE, sbc_pkg::BS_READ, sbc_pkg::BS_WRITE: begin
          if (preHit && (!apBit || (&preOkVec))) begin
            next_state = sbc_pkg::BS_PRECHARGING;
            next_timer = LOAD_RP;
          end else if (colHit) begin
            if (cmd == sbc_pkg::CMD_READ) begin
              next_state = apBit ? sbc_pkg::BS_READ_AP
                                 : sbc_pkg::BS_READ;
            end else begin
              next_state = apBit ? sbc_pkg::BS_WRITE_AP
                                 : sbc_pkg::BS_WRITE;
            end
            next_timer = apBit ? LOAD_AP : LOAD_BURST;
          end else if (stopHit && cur != sbc_pkg::BS_ACTIVE) begin
            next_state = sbc_pkg::BS_ACTIVE;
            next_timer = '0;
          end
        end
        // busy banks ride out their timer untouched
        sbc_pkg::BS_ACTIVATING, sbc_pkg::BS_PRECHARGING,
        sbc_pkg::BS_READ_AP, sbc_pkg::BS_WRITE_AP: begin
          next_state = cur;
        end
      endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        bankState[b] <= sbc_pkg::BS_IDLE;
        timer <= '0;
      end else begin
        bankState[b] <= next_state;
        timer <= next_timer;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // device-wide state

  assign curDev = (devTimer == '0) ? sbc_pkg::DS_NORMAL : devState;

  always_comb begin
    next_devState = curDev;
    next_devTimer = (devTimer == '0) ? '0 : devTimer - 1'b1;
    unique case (devState)
      sbc_pkg::DS_NORMAL, sbc_pkg::DS_REFRESH, sbc_pkg::DS_MODE: begin
        if (cmd == sbc_pkg::CMD_REFRESH && allIdle) begin
          next_devState = sbc_pkg::DS_REFRESH;
          next_devTimer = LOAD_RFC;
        end else if (cmd == sbc_pkg::CMD_MODE && allIdle) begin
          next_devState = sbc_pkg::DS_MODE;
          next_devTimer = LOAD_MRD;
        end
      end
      default: begin
        next_devState = sbc_pkg::DS_NORMAL;
        next_devTimer = '0;
      end
    endcase
  end

  // flags any command the current states do not support
  always_comb begin
    unique case (raw)
      sbc_pkg::CMD_NOP: next_illegal = 1'b0;
      sbc_pkg::CMD_ACTIVE: next_illegal = selCur != sbc_pkg::BS_IDLE;
      sbc_pkg::CMD_READ, sbc_pkg::CMD_WRITE:
        next_illegal = !sbc_pkg::col_ok(selCur);
      sbc_pkg::CMD_PRE:
        next_illegal = apBit ? !(&preOkVec) : !sbc_pkg::pre_ok(selCur);
      sbc_pkg::CMD_BST:
        next_illegal = !(lastCur == sbc_pkg::BS_READ ||
                         lastCur == sbc_pkg::BS_WRITE);
      sbc_pkg::CMD_REFRESH, sbc_pkg::CMD_MODE: next_illegal = !allIdle;
    endcase
    if (!devNormal && raw != sbc_pkg::CMD_NOP) begin
      next_illegal = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      devState <= sbc_pkg::DS_NORMAL;
      devTimer <= '0;
      cmdIllegal <= 1'b0;
    end else begin
      devState <= next_devState;
      devTimer <= next_devTimer;
      cmdIllegal <= cmdTaken && next_illegal;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modeWord <= '0;
      lastBurstBank <= '0;
    end else begin
      if (cmd == sbc_pkg::CMD_MODE && allIdle) begin
        modeWord <= link.addr;
      end
      if (colTaken) begin
        lastBurstBank <= link.bankSel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock enable history and self refresh exit

  // any edge with enable low on either side is not decoded, except self refresh entry on a falling enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ckePrev <= 1'b0;
      selfRefresh <= 1'b0;
      exitTimer <= '0;
    end else begin
      ckePrev <= link.cke;
      if (srEnter) begin
        selfRefresh <= 1'b1;
      end else if (selfRefresh && link.cke) begin
        selfRefresh <= 1'b0;
        exitTimer <= LOAD_XSR;
      end else if (exitTimer != '0) begin
        exitTimer <= exitTimer - 1'b1;
      end
    end
  end
endmodule : sbc_sdram_dev
